// *** logic/txn_engine.sv ***
// Purpose: Consume and query/response transaction engine for a CAN gateway
// Assumes: Frames arrive already decoded, one per cycle pulse
// Notes:   Process data leaves as a whole frame write with its index
`default_nettype none
module txn_engine (
   // Clock and reset
   input  wire logic                       clock,
   input  wire logic                       rst,
   // Configuration
   input  wire txn_engine_pkg::txn_cfg_t   cfg,
   input  wire txn_engine_pkg::frame_cfg_t frm_cfg [txn_engine_pkg::MAX_FRAMES],
   // Received frames
   input  wire logic                       rx_valid,
   input  wire txn_engine_pkg::rx_frame_t  rx_frame,
   // Query send request and completion
   input  wire logic                       query_done,
   output logic                            query_req,
   // Process data write port
   output logic                            pd_we,
   output logic [txn_engine_pkg::FRM_IDX_W-1:0] pd_idx,
   output logic [63:0]                     pd_data,
   output logic                            pd_clear,
   // Trigger and status byte writes
   output logic                            byte_we,
   output logic [9:0]                      byte_addr,
   output logic [7:0]                      byte_data,
   // State view
   output logic [7:0]                      transaction_state_byte,
   output logic                            offline
);
   localparam int unsigned NF = txn_engine_pkg::MAX_FRAMES;

   typedef enum logic [1:0] {
      Q_IDLE = 2'b00,
      Q_SEND = 2'b01,
      Q_WAIT = 2'b10
   } q_state_t;

   // Registers
   q_state_t                  q_state_reg, q_state_next;
   logic [14:0]               ms_cnt_reg;
   logic                      ms_tick;
   logic [15:0]               tmo_cnt_reg;
   logic [15:0]               ivl_cnt_reg;
   logic [NF-1:0]             got_reg;
   logic                      set_err_reg;
   logic [63:0]               buf_reg [NF];
   logic [7:0]                trig_reg;
   logic [7:0]                status_reg;
   logic [7:0]                status_next;
   logic                      stat_pend_reg;
   logic                      trig_pend_reg;
   logic                      pd_we_reg;
   logic [txn_engine_pkg::FRM_IDX_W-1:0] pd_idx_reg;
   logic [63:0]               pd_data_reg;
   logic                      pd_clear_reg;
   logic                      byte_we_reg;
   logic [9:0]                byte_addr_reg;
   logic [7:0]                byte_data_reg;
   logic [txn_engine_pkg::FRM_IDX_W-1:0] flush_idx_reg;
   logic                      flushing_reg;

   // Effective timeout and per-frame checks
   wire [15:0] tmo_eff   = cfg.consist_en ? cfg.timeout_ms : 16'h0000;
   wire        tmo_on    = (tmo_eff != 16'h0000);
   wire txn_engine_pkg::frame_cfg_t fc = frm_cfg[rx_frame.idx];
   wire        size_bad  = (rx_frame.dlc != fc.dlc) || (rx_frame.dlc > txn_engine_pkg::DLC_MAX);
   wire        const_bad = ((rx_frame.data ^ fc.const_val) & fc.const_mask) != 64'h0;
   wire        range_bad = (rx_frame.data[7:0] < fc.lo) || (rx_frame.data[7:0] > fc.hi);
   wire        frm_err   = size_bad || const_bad || range_bad;
   wire        idx_ok    = (rx_frame.idx <= cfg.last_frame);
   wire        rx_ok     = rx_valid && idx_ok && (!cfg.qr_mode || q_state_reg == Q_WAIT);
   wire [NF-1:0] idx_bit = NF'(1) << rx_frame.idx;
   wire [NF-1:0] need    = (NF'(1) << ({1'b0, cfg.last_frame} + 3'd1)) - NF'(1);
   wire [NF-1:0] got_now = got_reg | idx_bit;
   wire        all_in    = rx_ok && ((got_now & need) == need);
   wire        set_done  = cfg.consist_en ? all_in : rx_ok;
   wire        set_err   = cfg.consist_en ? (set_err_reg || frm_err) : frm_err;
   wire        tmo_hit   = tmo_on && ms_tick && (tmo_cnt_reg == 16'h0001) && !set_done;
   wire        ivl_hit   = ms_tick && (ivl_cnt_reg <= 16'h0001);
   wire        q_start   = cfg.qr_mode && (q_state_reg == Q_IDLE) &&
                           (cfg.cyclic ? ivl_hit : status_reg[txn_engine_pkg::ST_NOT_EXEC]);

   // Millisecond tick
   assign ms_tick = (ms_cnt_reg == 15'(txn_engine_pkg::CYC_PER_MS - 1));
   always_ff @(posedge clock) begin
      if (rst || ms_tick) ms_cnt_reg <= 15'h0000;
      else ms_cnt_reg <= ms_cnt_reg + 15'h0001;
   end

   // Offline timeout, restarted on consume reception or issued query, stopped by a query answer
   always_ff @(posedge clock) begin
      if (rst) begin
         tmo_cnt_reg <= 16'h0000;
         offline     <= 1'b0;
      end else if (set_done || (q_state_reg == Q_SEND && query_done)) begin
         // An answer ends the query wait; consume keeps watching
         tmo_cnt_reg <= (cfg.qr_mode && set_done) ? 16'h0000 : tmo_eff;
         offline     <= (offline || tmo_hit) && !(set_done && !set_err);
      end else if (tmo_hit) begin
         tmo_cnt_reg <= 16'h0000;
         offline     <= 1'b1;
      end else if (ms_tick && tmo_cnt_reg > 16'h0001) begin
         tmo_cnt_reg <= tmo_cnt_reg - 16'h0001;
      end
   end

   // Cyclic query interval
   always_ff @(posedge clock) begin
      if (rst) ivl_cnt_reg <= 16'h0000;
      else if (q_start) ivl_cnt_reg <= cfg.interval_ms;
      else if (ms_tick && ivl_cnt_reg != 16'h0000) ivl_cnt_reg <= ivl_cnt_reg - 16'h0001;
   end

   // Query master sequence: send query frames, then await response
   always_comb begin
      q_state_next = q_state_reg;
      case (q_state_reg)
         Q_IDLE:  if (q_start) q_state_next = Q_SEND;
         Q_SEND:  if (query_done) q_state_next = Q_WAIT;
         Q_WAIT:  if (set_done || tmo_hit || (tmo_cnt_reg == 16'h0000 && !tmo_on))
                     q_state_next = set_done || tmo_hit ? Q_IDLE : Q_WAIT;
         default: q_state_next = Q_IDLE;
      endcase
   end
   assign query_req = (q_state_reg == Q_SEND);
   always_ff @(posedge clock) begin
      if (rst) q_state_reg <= Q_IDLE;
      else q_state_reg <= q_state_next;
   end

   // Frame collection for consistency mode
   always_ff @(posedge clock) begin
      if (rst || set_done || !cfg.consist_en) begin
         got_reg     <= '0;
         set_err_reg <= 1'b0;
      end else if (rx_ok) begin
         got_reg     <= got_now;
         set_err_reg <= set_err_reg || frm_err;
      end
   end
   always_ff @(posedge clock) begin
      if (rx_ok) buf_reg[rx_frame.idx] <= rx_frame.data;
   end

   // Process data writes: direct, or flush after whole set checks good
   always_ff @(posedge clock) begin
      if (rst) begin
         pd_we_reg     <= 1'b0;
         pd_idx_reg    <= '0;
         pd_data_reg   <= 64'h0;
         pd_clear_reg  <= 1'b0;
         flushing_reg  <= 1'b0;
         flush_idx_reg <= '0;
      end else begin
         pd_we_reg    <= 1'b0;
         pd_clear_reg <= tmo_hit && (cfg.offline == txn_engine_pkg::OFF_CLEAR);
         if (!cfg.consist_en && rx_ok && !frm_err) begin
            pd_we_reg   <= 1'b1;
            pd_idx_reg  <= rx_frame.idx;
            pd_data_reg <= rx_frame.data;
         end else if (all_in && !set_err) begin
            flushing_reg  <= 1'b1;
            flush_idx_reg <= '0;
         end else if (flushing_reg) begin
            pd_we_reg     <= 1'b1;
            pd_idx_reg    <= flush_idx_reg;
            pd_data_reg   <= buf_reg[flush_idx_reg];
            flush_idx_reg <= flush_idx_reg + 1'b1;
            flushing_reg  <= (flush_idx_reg != cfg.last_frame);
         end
      end
   end
   assign pd_we    = pd_we_reg;
   assign pd_idx   = pd_idx_reg;
   assign pd_data  = pd_data_reg;
   assign pd_clear = pd_clear_reg;

   // Status byte next value
   always_comb begin
      status_next = status_reg;
      if (tmo_hit) status_next[txn_engine_pkg::ST_TIMEOUT] = 1'b1;
      if (set_done) begin
         status_next[txn_engine_pkg::ST_DATA_ERR] = set_err;
         status_next[txn_engine_pkg::ST_NOT_EXEC] = 1'b0;
         if (!set_err) status_next[txn_engine_pkg::ST_TIMEOUT] = 1'b0;
      end
      status_next[7:3] = 5'h00;
   end

   // Status and trigger bytes, written to data area when enabled
   always_ff @(posedge clock) begin
      if (rst) begin
         status_reg    <= txn_engine_pkg::ST_RESET;
         trig_reg      <= 8'h00;
         stat_pend_reg <= 1'b0;
         trig_pend_reg <= 1'b0;
         byte_we_reg   <= 1'b0;
         byte_addr_reg <= txn_engine_pkg::ADDR_FIRST_FREE;
         byte_data_reg <= 8'h00;
      end else begin
         status_reg <= status_next;
         if (cfg.trig_en && set_done) begin
            trig_reg      <= trig_reg + 8'h01;
            trig_pend_reg <= 1'b1;
         end
         byte_we_reg <= 1'b0;
         if (cfg.stat_en && status_next != status_reg) stat_pend_reg <= 1'b1;
         if (stat_pend_reg) begin
            byte_we_reg   <= 1'b1;
            byte_addr_reg <= cfg.stat_addr;
            byte_data_reg <= status_reg;
            stat_pend_reg <= cfg.stat_en && status_next != status_reg;
         end else if (trig_pend_reg) begin
            byte_we_reg   <= 1'b1;
            byte_addr_reg <= cfg.trig_addr;
            byte_data_reg <= trig_reg;
            trig_pend_reg <= cfg.trig_en && set_done;
         end
      end
   end
   assign byte_we                = byte_we_reg;
   assign byte_addr              = byte_addr_reg;
   assign byte_data              = byte_data_reg;
   assign transaction_state_byte = status_reg;
endmodule
`default_nettype wire

// *** logic/txn_engine_pkg.sv ***
// Purpose: Shared constants and carriers for the consume / query-response engine
// Assumes: 25 MHz clock, times counted in milliseconds
// Notes:   Status byte layout and timing counts live here
`default_nettype none
package txn_engine_pkg;
   // Clock and time base
   localparam int unsigned CLK_HZ        = 25000000;
   localparam int unsigned MS_PER_TICK   = 1;
   localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000 * MS_PER_TICK;
   localparam int unsigned MS_CNT_W      = 15;
   // Timeout and interval limits
   localparam logic [15:0] TMO_DEFAULT   = 16'h0000;
   localparam logic [15:0] TMO_MIN       = 16'h000A;
   localparam logic [15:0] IVL_MIN       = 16'h0005;
   localparam logic [15:0] IVL_DEFAULT   = 16'h03E8;
   // Frame geometry
   localparam int unsigned MAX_FRAMES    = 4;
   localparam int unsigned FRM_IDX_W     = 2;
   localparam int unsigned FRM_BYTES     = 8;
   localparam logic [3:0]  DLC_MAX       = 4'h8;
   // Status byte bit positions
   localparam int unsigned ST_TIMEOUT    = 0;
   localparam int unsigned ST_DATA_ERR   = 1;
   localparam int unsigned ST_NOT_EXEC   = 2;
   localparam logic [7:0]  ST_RESET      = 8'h04;
   // Default data-area addresses (first free)
   localparam logic [9:0]  ADDR_FIRST_FREE = 10'h000;
   // Offline handling
   typedef enum logic [0:0] {
      OFF_CLEAR  = 1'b0,
      OFF_FREEZE = 1'b1
   } offline_opt_t;
   // One received CAN frame
   typedef struct packed {
      logic [FRM_IDX_W-1:0] idx;
      logic [3:0]           dlc;
      logic [63:0]          data;
   } rx_frame_t;
   // Expected frame contents: constant mask/value plus range limit on byte 0
   typedef struct packed {
      logic [3:0]  dlc;
      logic [63:0] const_mask;
      logic [63:0] const_val;
      logic [7:0]  lo;
      logic [7:0]  hi;
   } frame_cfg_t;
   // Static transaction configuration
   typedef struct packed {
      logic                 qr_mode;
      logic                 cyclic;
      logic                 consist_en;
      offline_opt_t         offline;
      logic [15:0]          timeout_ms;
      logic [15:0]          interval_ms;
      logic                 trig_en;
      logic [9:0]           trig_addr;
      logic                 stat_en;
      logic [9:0]           stat_addr;
      logic [FRM_IDX_W-1:0] last_frame;
   } txn_cfg_t;
endpackage
`default_nettype wire

// *** tb/txn_engine_props.sv ***
// Purpose: Port-level checks for the transaction engine
// Assumes: One clock, synchronous active-high reset
// Notes:   Attached by bind below the module
`default_nettype none
module txn_engine_props (
   // Clock and reset
   input wire logic                                  clock,
   input wire logic                                  rst,
   // Stimulus side
   input wire txn_engine_pkg::txn_cfg_t              cfg,
   input wire logic                                  rx_valid,
   input wire txn_engine_pkg::rx_frame_t             rx_frame,
   input wire logic                                  query_done,
   // Design outputs
   input wire logic                                  query_req,
   input wire logic                                  pd_we,
   input wire logic [txn_engine_pkg::FRM_IDX_W-1:0]  pd_idx,
   input wire logic [63:0]                           pd_data,
   input wire logic                                  pd_clear,
   input wire logic                                  byte_we,
   input wire logic [9:0]                            byte_addr,
   input wire logic [7:0]                            byte_data,
   input wire logic [7:0]                            transaction_state_byte,
   input wire logic                                  offline
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // Query handed to the sender, status change seen
   sequence s_query_sent;
      query_req && query_done;
   endsequence
   sequence s_state_moved;
      cfg.stat_en && $changed(transaction_state_byte);
   endsequence
   // Checks
   a_reserved_zero: assert property (transaction_state_byte[7:3] == 5'h00)
      else $error("reserved status bits set");
   a_direct_copy: assert property (pd_we && !cfg.consist_en |-> $past(rx_valid)
      && pd_data == $past(rx_frame.data) && pd_idx == $past(rx_frame.idx))
      else $error("direct write does not match frame");
   a_exec_seen: assert property (pd_we |-> !transaction_state_byte[2])
      else $error("not-executed bit still set on write");
   a_no_tmo_direct: assert property (!cfg.consist_en |-> !offline)
      else $error("offline without consistency");
   a_offline_bit: assert property (offline == transaction_state_byte[0])
      else $error("timeout bit differs from offline");
   a_clear_drop: assert property ($rose(offline) && cfg.offline == txn_engine_pkg::OFF_CLEAR
      |-> ##[0:1] pd_clear) else $error("no clear on offline");
   a_freeze_keep: assert property (pd_clear |-> cfg.offline == txn_engine_pkg::OFF_CLEAR)
      else $error("clear under freeze option");
   a_status_write: assert property (s_state_moved |=> byte_we
      && byte_addr == cfg.stat_addr && byte_data == $past(transaction_state_byte))
      else $error("status byte not rewritten");
   a_query_wait: assert property (s_query_sent |=> !query_req)
      else $error("query still requested after send");
   a_query_hold: assert property (query_req && !query_done |=> query_req)
      else $error("query request dropped early");
endmodule
bind txn_engine txn_engine_props u_props (.clock, .rst, .cfg, .rx_valid, .rx_frame,
   .query_done, .query_req, .pd_we, .pd_idx, .pd_data, .pd_clear, .byte_we,
   .byte_addr, .byte_data, .transaction_state_byte, .offline);
`default_nettype wire

// *** tb/can_node_model.sv ***
// Purpose: Other nodes on the CAN side: send frames, answer queries
// Assumes: Drives on the falling edge
// Notes:   Frame lines show inverted junk outside a valid cycle
`default_nettype none
module can_node_model (
   // Clock
   input wire logic                       clock,
   // Control from bench
   input wire logic                       auto_en,
   input wire txn_engine_pkg::rx_frame_t  resp,
   // Engine side
   input wire logic                       query_req,
   output logic                           rx_valid,
   output txn_engine_pkg::rx_frame_t      rx_frame,
   output logic                           query_done
);
   timeunit 1ns;
   timeprecision 1ps;
   // One frame, one cycle
   task automatic send(input txn_engine_pkg::rx_frame_t f);
      @(negedge clock);
      rx_valid = 1'b1;
      rx_frame = f;
      @(negedge clock);
      rx_valid = 1'b0;
      rx_frame = txn_engine_pkg::rx_frame_t'(~f);
   endtask
   initial begin
      rx_valid = 1'b0;
      rx_frame = '0;
      query_done = 1'b0;
   end
   // Sends the query, then answers; never a remote request
   always @(posedge clock) begin
      if (auto_en && query_req) begin
         repeat (2) @(negedge clock);
         query_done = 1'b1;
         @(negedge clock);
         query_done = 1'b0;
         repeat (3) @(negedge clock);
         send(resp);
      end
   end
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// Purpose: Self-checking bench for the transaction engine
// Assumes: 25 MHz clock; a one-millisecond timeout keeps the run short
// Notes:   Expiry and recovery checked in the timeout test
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic                       clock, rst, auto_en, query_req, rx_valid, query_done;
   logic                       pd_we, pd_clear, byte_we, offline;
   logic [1:0]                 pd_idx, idx_last;
   logic [63:0]                pd_data, pd_last;
   logic [9:0]                 byte_addr;
   logic [7:0]                 byte_data, state, trig_last, stat_last;
   txn_engine_pkg::txn_cfg_t   cfg;
   txn_engine_pkg::frame_cfg_t frm_cfg [txn_engine_pkg::MAX_FRAMES];
   txn_engine_pkg::rx_frame_t  rx_frame, resp;
   txn_engine_pkg::rx_frame_t  bad [4];
   int                         n_errors, cmp_count, n_pd, n_clr;
   txn_engine u_txn_engine (.clock, .rst, .cfg, .frm_cfg, .rx_valid, .rx_frame,
      .query_done, .query_req, .pd_we, .pd_idx, .pd_data, .pd_clear, .byte_we,
      .byte_addr, .byte_data, .transaction_state_byte(state), .offline);
   can_node_model u_can_node_model (.clock, .auto_en, .resp, .query_req, .rx_valid,
      .rx_frame, .query_done);
   // Clock
   always #20 clock = ~clock;
   // Output monitor
   always @(posedge clock) begin
      if (pd_we) begin
         n_pd++;
         pd_last <= pd_data;
         idx_last <= pd_idx;
      end
      if (pd_clear) n_clr++;
      if (byte_we && byte_addr == cfg.trig_addr) trig_last <= byte_data;
      if (byte_we && byte_addr == cfg.stat_addr) stat_last <= byte_data;
   end
   function automatic txn_engine_pkg::rx_frame_t mk(input logic [1:0] i,
      input logic [3:0] d, input logic [7:0] b7, input logic [7:0] b0);
      mk = '{idx: i, dlc: d, data: {b7, 48'h0, b0}};
   endfunction
   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic do_reset;
      rst = 1'b1;
      repeat (3) @(negedge clock);
      rst = 1'b0;
      n_pd = 0;
      n_clr = 0;
   endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Watchdog
   initial begin
      repeat (60000) @(posedge clock);
      n_errors++;
      $display("MISMATCH watchdog expected done seen hang");
      stop_test();
   end
   // Test sequence
   initial begin
      clock = 1'b0;
      auto_en = 1'b0;
      n_errors = 0;
      cmp_count = 0;
      cfg = '0;
      cfg.stat_en = 1'b1;
      cfg.stat_addr = 10'h001;
      cfg.trig_en = 1'b1;
      cfg.trig_addr = 10'h010;
      resp = mk(2'h0, 4'h8, 8'h5A, 8'h15);
      bad = '{mk(2'h0, 4'h8, 8'h5A, 8'h30), mk(2'h0, 4'h8, 8'h00, 8'h15),
              mk(2'h0, 4'h4, 8'h5A, 8'h15), mk(2'h1, 4'h8, 8'h5A, 8'h15)};
      for (int i = 0; i < 4; i++) begin
         frm_cfg[i] = '{4'h8, 64'hFF00_0000_0000_0000, 64'h5A00_0000_0000_0000, 8'h10, 8'h20};
      end
      do_reset();
      chk("state", 8'h04, state);
      chk("offline", 1'b0, offline);
      $display("test reset done");
      u_can_node_model.send(resp);
      repeat (6) @(negedge clock);
      chk("pd_count", 1, n_pd);
      chk("pd_data", resp.data, pd_last);
      chk("state", 8'h00, state);
      chk("stat_byte", 8'h00, stat_last);
      chk("trig_byte", 8'h01, trig_last);
      $display("test direct done");
      for (int i = 0; i < 4; i++) begin
         u_can_node_model.send(bad[i]);
         repeat (6) @(negedge clock);
         chk("pd_count", 1, n_pd);
         chk("err_bit", 1'b1, state[1]);
      end
      u_can_node_model.send(resp);
      repeat (6) @(negedge clock);
      chk("err_bit", 1'b0, state[1]);
      $display("test errors done");
      cfg.consist_en = 1'b1;
      cfg.last_frame = 2'h1;
      do_reset();
      u_can_node_model.send(mk(2'h1, 4'h8, 8'h5A, 8'h12));
      repeat (6) @(negedge clock);
      chk("pd_count", 0, n_pd);
      u_can_node_model.send(resp);
      repeat (6) @(negedge clock);
      chk("pd_count", 2, n_pd);
      chk("pd_idx", 2'h1, idx_last);
      $display("test consistency done");
      // Short timeout so that expiry falls inside the run
      cfg.last_frame = 2'h0;
      cfg.timeout_ms = 16'h0001;
      do_reset();
      u_can_node_model.send(resp);
      for (int k = 0; k < 26000 && !offline; k++) @(negedge clock);
      repeat (2) @(negedge clock);
      chk("offline", 1'b1, offline);
      chk("state", 8'h01, state);
      chk("clr_count", 1, n_clr);
      u_can_node_model.send(resp);
      repeat (6) @(negedge clock);
      chk("offline", 1'b0, offline);
      chk("state", 8'h00, state);
      $display("test timeout done");
      cfg.qr_mode = 1'b1;
      cfg.last_frame = 2'h0;
      cfg.timeout_ms = 16'h000A;
      do_reset();
      u_can_node_model.send(resp);
      repeat (6) @(negedge clock);
      chk("pd_count", 0, n_pd);
      auto_en = 1'b1;
      for (int k = 0; k < 40000 && n_pd == 0; k++) @(negedge clock);
      chk("pd_count", 1, n_pd);
      chk("offline", 1'b0, offline);
      chk("state", 8'h00, state);
      $display("test query done");
      stop_test();
   end
endmodule
`default_nettype wire
